// file: design/sdp_ctrl.sv
/*
 * Bus controller for one RAM port: an APB slave whose registers launch
 * single reads, writes, counter advances and counter clears on the port.
 * Assumes the RAM runs on the same pclk and the APB master is on pclk.
 */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module sdp_ctrl (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave.
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // RAM port.
    sdp_port_if.host          port
);
    import sdp_pkg::*;

    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_GUARD} sdp_state_t;

    sdp_state_t        state_q;
    sdp_op_t           op_q;
    logic              mode_q;
    logic              done_q;
    logic [1:0]        wait_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic              wr_acc;
    logic              launch;
    logic              finish;
    sdp_op_t           cmd_op;

    // ************************************************************
    // APB access decode.
    // ************************************************************

    // Zero wait states; unmapped addresses read as zero, writes dropped.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc  = psel && penable && pwrite;
    assign launch  = wr_acc && paddr == REG_CMD && state_q == ST_IDLE;
    assign finish  = (state_q == ST_WAIT || state_q == ST_GUARD)
                     && wait_q == WAIT_RST;
    // Operation carried by a command write, decoded for the launch edge.
    assign cmd_op  = sdp_op_t'(pwdata[CMD_OP_LSB+:2]);

    always_comb begin
        prdata = '0;
        unique case (paddr)
            REG_CTRL:  prdata[CTRL_MODE_BIT] = mode_q;
            REG_ADDR:  prdata[ADDR_W-1:0] = addr_q;
            REG_WDATA: prdata[DATA_W-1:0] = wdata_q;
            REG_CMD:   prdata[CMD_OP_LSB+:2] = op_q;
            REG_STAT: begin
                prdata[STAT_BUSY_BIT] = state_q != ST_IDLE;
                prdata[STAT_DONE_BIT] = done_q;
            end
            REG_RDATA: prdata[DATA_W-1:0] = rdata_q;
            default:   prdata = '0;
        endcase
    end

    // Setup registers; mode and operands only change while idle so the
    // mode select stays static during any port traffic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= CTRL_MODE_RST;
            addr_q  <= ADDR_RST;
            wdata_q <= DATA_RST;
            op_q    <= SDP_OP_READ;
        end else if (wr_acc && state_q == ST_IDLE) begin
            unique case (paddr)
                REG_CTRL:  mode_q  <= pwdata[CTRL_MODE_BIT];
                REG_ADDR:  addr_q  <= pwdata[ADDR_W-1:0];
                REG_WDATA: wdata_q <= pwdata[DATA_W-1:0];
                REG_CMD:   op_q    <= sdp_op_t'(pwdata[CMD_OP_LSB+:2]);
                default: ;
            endcase
        end
    end

    // Done flag: a finish in the same cycle as a clear keeps it set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (wr_acc && paddr == REG_STAT
                     && pwdata[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // ************************************************************
    // Port sequencer.
    // ************************************************************

    // All port pins come from flops on pclk. Reads keep the port selected
    // while waiting, because the pipelined output needs two selected
    // cycles. After a write the controller waits out the write-to-read
    // delay so a reader on the other port sees settled data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q                      <= ST_IDLE;
            wait_q                       <= WAIT_RST;
            rdata_q                      <= DATA_RST;
            port.chip_select_low_active  <= 1'b1;
            port.chip_select_high_active <= 1'b0;
            port.read_write              <= 1'b1;
            port.output_enable_n         <= 1'b1;
            port.address_load_strobe_n   <= 1'b1;
            port.counter_advance_n       <= 1'b1;
            port.counter_clear_n         <= 1'b1;
            port.host_dq                 <= DATA_RST;
            port.host_dq_oe_n            <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: if (launch) begin
                    state_q                      <= ST_ISSUE;
                    port.chip_select_low_active  <= 1'b0;
                    port.chip_select_high_active <= 1'b1;
                    port.read_write              <= cmd_op != SDP_OP_WRITE;
                    port.address_load_strobe_n   <=
                        !(cmd_op == SDP_OP_READ || cmd_op == SDP_OP_WRITE);
                    port.counter_advance_n       <= cmd_op != SDP_OP_NEXT;
                    port.counter_clear_n         <= cmd_op != SDP_OP_CLEAR;
                    port.host_dq                 <= wdata_q;
                    port.host_dq_oe_n            <= cmd_op != SDP_OP_WRITE;
                end
                ST_ISSUE: begin
                    port.address_load_strobe_n <= 1'b1;
                    port.counter_advance_n     <= 1'b1;
                    port.counter_clear_n       <= 1'b1;
                    port.host_dq_oe_n          <= 1'b1;
                    port.read_write            <= 1'b1;
                    if (op_q == SDP_OP_WRITE) begin
                        state_q                      <= ST_GUARD;
                        wait_q <= 2'(WRITE_TO_READ_CYC - 1);
                        port.chip_select_low_active  <= 1'b1;
                        port.chip_select_high_active <= 1'b0;
                    end else begin
                        state_q              <= ST_WAIT;
                        port.output_enable_n <= 1'b0;
                        wait_q <= 2'(mode_q ? PIPE_LAT - 1
                                            : FLOW_LAT - 1);
                    end
                end
                ST_WAIT: if (finish) begin
                    state_q                      <= ST_IDLE;
                    rdata_q                      <= port.dq;
                    port.output_enable_n         <= 1'b1;
                    port.chip_select_low_active  <= 1'b1;
                    port.chip_select_high_active <= 1'b0;
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
                ST_GUARD: if (finish) begin
                    state_q <= ST_IDLE;
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
            endcase
        end
    end

    assign port.addr               = addr_q;
    assign port.output_mode_select = mode_q;

endmodule

`default_nettype wire

// file: design/sdp_pkg.sv
/*
 * Shared constants and types for the synchronous dual-port RAM model and
 * for the bus-side controller that drives one of its ports.
 * Assumes a single 50 MHz clock (pclk) for both ends.
 */
package sdp_pkg;

    // ************************************************************
    // Array geometry.
    // ************************************************************
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 8;
    localparam int DEPTH     = 65536;
    localparam int NUM_PORTS = 2;

    // ************************************************************
    // Timing, in nanoseconds and derived cycles of pclk.
    // ************************************************************
    localparam int CLK_NS                = 20;
    localparam int CLOCK_TO_CLOCK_NS     = 15;
    localparam int WRITE_TO_READ_NS      = 35;
    localparam int FLOW_CLOCK_TO_DATA_NS = 20;
    // Least times round up to whole cycles.
    localparam int WRITE_TO_READ_CYC =
        (WRITE_TO_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOW_LAT =
        (FLOW_CLOCK_TO_DATA_NS + CLK_NS - 1) / CLK_NS;
    localparam int PIPE_LAT = FLOW_LAT + 1;

    // ************************************************************
    // Controller register map (APB byte offsets) and fields.
    // ************************************************************
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD   = 8'h0C;
    localparam logic [7:0] REG_STAT  = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;

    localparam int CTRL_MODE_BIT = 0;
    localparam int CMD_OP_LSB    = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    localparam logic             CTRL_MODE_RST = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
    localparam logic [1:0]        WAIT_RST     = 2'h0;

    // Port operations launched through the command register.
    typedef enum logic [1:0] {
        SDP_OP_READ  = 2'h0,
        SDP_OP_WRITE = 2'h1,
        SDP_OP_NEXT  = 2'h2,
        SDP_OP_CLEAR = 2'h3
    } sdp_op_t;

endpackage

// file: design/sdp_port_if.sv
/*
 * One RAM port as seen between the RAM and the party that drives it.
 * Assumes both ends run on the same pclk; the shared data bus is resolved
 * here from the two active-low output enables.
 */
`timescale 1ns/10ps
`default_nettype none

interface sdp_port_if;
    import sdp_pkg::*;

    logic              chip_select_low_active;
    logic              chip_select_high_active;
    logic              read_write;
    logic              output_enable_n;
    logic [ADDR_W-1:0] addr;
    logic              address_load_strobe_n;
    logic              counter_advance_n;
    logic              counter_clear_n;
    logic              output_mode_select;
    logic [DATA_W-1:0] host_dq;
    logic              host_dq_oe_n;
    logic [DATA_W-1:0] ram_dq;
    logic              ram_dq_oe_n;
    logic [DATA_W-1:0] dq;

    // The RAM wins if both drive; an undriven bus reads as zero.
    assign dq = !ram_dq_oe_n ? ram_dq : (!host_dq_oe_n ? host_dq : '0);

    modport ram (
        input  chip_select_low_active, chip_select_high_active, read_write,
               output_enable_n, addr, address_load_strobe_n,
               counter_advance_n, counter_clear_n, output_mode_select, dq,
        output ram_dq, ram_dq_oe_n
    );

    modport host (
        output chip_select_low_active, chip_select_high_active, read_write,
               output_enable_n, addr, address_load_strobe_n,
               counter_advance_n, counter_clear_n, output_mode_select,
               host_dq, host_dq_oe_n,
        input  dq
    );
endinterface

`default_nettype wire

// file: design/sdp_ram.sv
/*
 * Synchronous dual-port static RAM, 64K x 8, two independent ports with
 * registered control, burst address counter and selectable flow-through
 * or pipelined read output.
 * Assumes both ports are driven from logic on pclk; presetn clears control
 * state and the read registers, the array itself is not initialised.
 */
`timescale 1ns/10ps
`default_nettype none

module sdp_ram (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // The two ports.
    sdp_port_if.ram   port_a,
    sdp_port_if.ram   port_b
);
    import sdp_pkg::*;

    // ************************************************************
    // Storage.
    // ************************************************************
    logic [DATA_W-1:0] mem [DEPTH];

    // ************************************************************
    // Per-port signals gathered into arrays.
    // ************************************************************
    logic [NUM_PORTS-1:0] sel;
    logic [NUM_PORTS-1:0] rd_en;
    logic [NUM_PORTS-1:0] wr_en;
    logic [NUM_PORTS-1:0] rw;
    logic [NUM_PORTS-1:0] oe_n;
    logic [NUM_PORTS-1:0] ads_n;
    logic [NUM_PORTS-1:0] adv_n;
    logic [NUM_PORTS-1:0] clr_n;
    logic [NUM_PORTS-1:0] pipe;
    logic [NUM_PORTS-1:0] cs_lo;
    logic [NUM_PORTS-1:0] cs_hi;
    logic [NUM_PORTS-1:0] drive;
    logic [NUM_PORTS-1:0] flow_drv_q;
    logic [NUM_PORTS-1:0] pipe_sel_q;
    logic [NUM_PORTS-1:0] pipe_drv_q;
    logic [ADDR_W-1:0]    ext_addr [NUM_PORTS];
    logic [ADDR_W-1:0]    use_addr [NUM_PORTS];
    logic [ADDR_W-1:0]    cnt_q    [NUM_PORTS];
    logic [DATA_W-1:0]    din      [NUM_PORTS];
    logic [DATA_W-1:0]    flow_q   [NUM_PORTS];
    logic [DATA_W-1:0]    pipe_q   [NUM_PORTS];
    logic [DATA_W-1:0]    dout     [NUM_PORTS];

    // ************************************************************
    // Port A and port B pin mapping.
    // ************************************************************

    // Inputs come from logic on pclk, so they are used as sampled at the
    // edge; the edge itself is the input register of the real part.
    assign cs_lo[0]    = port_a.chip_select_low_active;
    assign cs_hi[0]    = port_a.chip_select_high_active;
    assign rw[0]       = port_a.read_write;
    assign oe_n[0]     = port_a.output_enable_n;
    assign ads_n[0]    = port_a.address_load_strobe_n;
    assign adv_n[0]    = port_a.counter_advance_n;
    assign clr_n[0]    = port_a.counter_clear_n;
    assign pipe[0]     = port_a.output_mode_select;
    assign ext_addr[0] = port_a.addr;
    assign din[0]      = port_a.dq;

    assign cs_lo[1]    = port_b.chip_select_low_active;
    assign cs_hi[1]    = port_b.chip_select_high_active;
    assign rw[1]       = port_b.read_write;
    assign oe_n[1]     = port_b.output_enable_n;
    assign ads_n[1]    = port_b.address_load_strobe_n;
    assign adv_n[1]    = port_b.counter_advance_n;
    assign clr_n[1]    = port_b.counter_clear_n;
    assign pipe[1]     = port_b.output_mode_select;
    assign ext_addr[1] = port_b.addr;
    assign din[1]      = port_b.dq;

    // Data pins: the enable is low while the RAM drives the bus.
    assign port_a.ram_dq      = dout[0];
    assign port_a.ram_dq_oe_n = !drive[0];
    assign port_b.ram_dq      = dout[1];
    assign port_b.ram_dq_oe_n = !drive[1];

    // ************************************************************
    // Per-port control, counter and read path.
    // ************************************************************
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port

        // Both chip selects must agree for the port to be selected.
        assign sel[i]   = !cs_lo[i] && cs_hi[i];
        assign rd_en[i] = sel[i] && rw[i];
        assign wr_en[i] = sel[i] && !rw[i];

        // Internal address used this edge. Clear beats load beats advance,
        // and a cleared cycle already accesses address zero, so a clear
        // costs no dead cycle. Advancing ignores the chip selects.
        always_comb begin
            if (!clr_n[i]) begin
                use_addr[i] = ADDR_RST;
            end else if (!ads_n[i]) begin
                use_addr[i] = ext_addr[i];
            end else if (!adv_n[i]) begin
                use_addr[i] = cnt_q[i] + ADDR_W'(1);
            end else begin
                use_addr[i] = cnt_q[i];
            end
        end

        // The counter always remembers the address last used, so a burst
        // can continue from a loaded or cleared address.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q[i] <= ADDR_RST;
            end else begin
                cnt_q[i] <= use_addr[i];
            end
        end

        // Flow-through read register; it is only refreshed by a selected
        // read, so with the address held the output stays constant.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flow_q[i] <= DATA_RST;
            end else if (rd_en[i]) begin
                flow_q[i] <= mem[use_addr[i]];
            end
        end

        // Pipelined output stage adds exactly one clock of latency.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pipe_q[i] <= DATA_RST;
            end else begin
                pipe_q[i] <= flow_q[i];
            end
        end

        // Output drive state is decided by the controls of the previous
        // edge. In pipelined mode the drive needs a read at one edge and a
        // selection at the next, so two selected cycles re-open the bus,
        // and a deselect at any edge floats the bus right after it.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flow_drv_q[i] <= 1'b0;
                pipe_sel_q[i] <= 1'b0;
                pipe_drv_q[i] <= 1'b0;
            end else begin
                flow_drv_q[i] <= rd_en[i];
                pipe_sel_q[i] <= rd_en[i];
                pipe_drv_q[i] <= pipe_sel_q[i] && sel[i];
            end
        end

        // The mode select is a static strap, read directly; changing it
        // during traffic gives one garbled cycle, which the driver avoids.
        // The output enable acts without the clock.
        always_comb begin
            if (pipe[i]) begin
                dout[i]  = pipe_q[i];
                drive[i] = pipe_drv_q[i] && !oe_n[i];
            end else begin
                dout[i]  = flow_q[i];
                drive[i] = flow_drv_q[i] && !oe_n[i];
            end
        end
    end

    // ************************************************************
    // Array writes.
    // ************************************************************

    // Both ports write with no arbitration. If both write one word at the
    // same edge, port B's data is kept; a read of a word written at the
    // same edge returns the old contents, which is why readers on the
    // other port must allow the write-to-read delay.
    always_ff @(posedge pclk) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_en[p]) begin
                mem[use_addr[p]] <= din[p];
            end
        end
    end

endmodule

`default_nettype wire

// file: tb/sdp_port_monitor.sv
/* Checker on the pins of one RAM port.
   Assumes one pclk domain and the interface signals as plain inputs. */
`timescale 1ns/10ps
`default_nettype none
module sdp_port_monitor (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Port pins.
    input wire logic chip_select_low_active,
    input wire logic chip_select_high_active,
    input wire logic read_write,
    input wire logic output_enable_n,
    input wire logic output_mode_select,
    input wire logic ram_dq_oe_n
);
    wire logic sel;
    // ****************************************
    // Output drive rules.
    // ****************************************
    // Both selects must agree before the port counts as selected.
    assign sel = !chip_select_low_active && chip_select_high_active;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_deselect_float: assert property (!sel |=> ram_dq_oe_n)
        else $error("port drove after a deselected edge");
    a_oe_float: assert property (output_enable_n |-> ram_dq_oe_n)
        else $error("port drove with output enable off");
    a_write_no_drive: assert property (sel && !read_write |=>
        ram_dq_oe_n)
        else $error("port drove after a write edge");
    a_read_source: assert property (!ram_dq_oe_n |->
        $past(sel) && $past(read_write))
        else $error("port drove without a read before it");
    a_flow_drive: assert property (!output_mode_select && sel &&
        read_write |=> !ram_dq_oe_n || output_enable_n)
        else $error("flow read not driven next cycle");
    a_pipe_late: assert property (output_mode_select && sel &&
        !$past(sel) |=> ram_dq_oe_n)
        else $error("pipelined read driven too early");
    a_pipe_drive: assert property (output_mode_select && sel &&
        read_write ##1 sel && read_write |=> !ram_dq_oe_n || output_enable_n)
        else $error("pipelined read not driven");
    a_pipe_two_sel: assert property (output_mode_select &&
        !ram_dq_oe_n |-> $past(sel) && $past(sel, 2))
        else $error("pipelined drive without two selected edges");
    c_flow_read: cover property (!output_mode_select && !ram_dq_oe_n);
    c_pipe_read: cover property (output_mode_select && !ram_dq_oe_n);
    c_write: cover property (sel && !read_write);
endmodule
`default_nettype wire

// file: tb/sync_dual_port_ram_port_test.sv
/* Bench: two APB controllers drive the two ports of the RAM.
   Assumes one pclk and that both controllers answer without wait. */
`timescale 1ns/10ps
`default_nettype none
module sync_dual_port_ram_port_test;
    import sdp_pkg::*;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr   [2];
    logic        psel    [2];
    logic        penable [2];
    logic        pwrite  [2];
    logic [31:0] pwdata  [2];
    logic [31:0] prdata  [2];
    logic        pready  [2];
    logic [7:0]  mem     [int];
    logic [15:0] cnt     [2];
    int          miscompares = 0;
    int          n_checks = 0;
    int          seed = 3;
    sdp_port_if i_sdp_port_if_a ();
    sdp_port_if i_sdp_port_if_b ();
    sdp_ram i_sdp_ram (.pclk(pclk), .presetn(presetn),
        .port_a(i_sdp_port_if_a), .port_b(i_sdp_port_if_b));
    sdp_ctrl i_sdp_ctrl_a (.pclk(pclk), .presetn(presetn), .paddr(paddr[0]),
        .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]),
        .pwdata(pwdata[0]), .prdata(prdata[0]), .pready(pready[0]),
        .pslverr(), .port(i_sdp_port_if_a));
    sdp_ctrl i_sdp_ctrl_b (.pclk(pclk), .presetn(presetn), .paddr(paddr[1]),
        .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]),
        .pwdata(pwdata[1]), .prdata(prdata[1]), .pready(pready[1]),
        .pslverr(), .port(i_sdp_port_if_b));
    sdp_port_monitor i_sdp_port_monitor (.pclk(pclk), .presetn(presetn),
        .chip_select_low_active(i_sdp_port_if_a.chip_select_low_active),
        .chip_select_high_active(i_sdp_port_if_a.chip_select_high_active),
        .read_write(i_sdp_port_if_a.read_write),
        .output_enable_n(i_sdp_port_if_a.output_enable_n),
        .output_mode_select(i_sdp_port_if_a.output_mode_select),
        .ram_dq_oe_n(i_sdp_port_if_a.ram_dq_oe_n));
    // ****************************************
    // Bus tasks and expectations.
    // ****************************************
    // The idle edge at the end keeps psel from being assigned twice at once.
    // Only the watchdog ends a wait for pready.
    task automatic apb(input int p, input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        paddr[p] <= a;
        pwrite[p] <= w;
        pwdata[p] <= d;
        psel[p] <= 1'b1;
        @(posedge pclk);
        penable[p] <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready[p] !== 1'b1);
        r = prdata[p];
        psel[p] <= 1'b0;
        penable[p] <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One port operation; busy is polled under a bound so a hang shows.
    task automatic do_op(input int p, input logic [1:0] op,
        input logic [15:0] a, input logic [7:0] d, output logic [31:0] r);
        logic [31:0] s;
        int          t = 0;
        apb(p, 1'b1, REG_ADDR, 32'(a), s);
        apb(p, 1'b1, REG_WDATA, 32'(d), s);
        apb(p, 1'b1, REG_CMD, 32'(op), s);
        do begin
            apb(p, 1'b0, REG_STAT, 32'h00000000, s);
            t++;
        end while (s[STAT_BUSY_BIT] !== 1'b0 && t < 20);
        check(32'(s[STAT_DONE_BIT]), 32'h00000001);
        apb(p, 1'b1, REG_STAT, 32'h00000002, s);
        apb(p, 1'b0, REG_RDATA, 32'h00000000, r);
    endtask
    function automatic logic [15:0] exp_addr(input logic [1:0] op,
        input logic [15:0] a, input logic [15:0] c);
        case (op)
            SDP_OP_NEXT:  return c + 16'h0001;
            SDP_OP_CLEAR: return 16'h0000;
            default:      return a;
        endcase
    endfunction
    task automatic results;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #400000;
        miscompares++;
        results();
    end
    // Random pairs run on both ports at once; a write that would meet
    // the other port's access at one word drops port B for that round.
    initial begin
        logic [31:0] r [2];
        logic [1:0]  op [2];
        logic [15:0] a [2];
        logic [7:0]  d [2];
        logic [15:0] e [2];
        logic        both;
        presetn = 1'b0;
        for (int p = 0; p < 2; p++) begin
            psel[p] = 1'b0;
            penable[p] = 1'b0;
            pwrite[p] = 1'b0;
            paddr[p] = 8'h00;
            pwdata[p] = 32'h00000000;
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 1'b0, 8'h3C, 32'h00000000, r[0]);
        check(r[0], 32'h00000000);
        apb(1, 1'b0, REG_CTRL, 32'h00000000, r[1]);
        check(r[1], 32'(CTRL_MODE_RST));
        for (int m = 0; m < 2; m++) begin
            for (int p = 0; p < 2; p++) begin
                apb(p, 1'b1, REG_CTRL, 32'(m), r[p]);
            end
            for (int i = 0; i < 32; i++) begin
                d[0] = 8'($random(seed));
                do_op(i % 2, SDP_OP_WRITE, 16'(i), d[0], r[0]);
                mem[i] = d[0];
                cnt[i % 2] = 16'(i);
            end
            do_op(0, SDP_OP_CLEAR, 16'hFFFF, 8'h00, r[0]);
            check(r[0], 32'(mem[0]));
            cnt[0] = 16'h0000;
            for (int k = 0; k < 30; k++) begin
                for (int p = 0; p < 2; p++) begin
                    op[p] = 2'($random(seed));
                    a[p] = 16'($random(seed) & 15);
                    d[p] = 8'($random(seed));
                    e[p] = exp_addr(op[p], a[p], cnt[p]);
                end
                both = !((op[0] == SDP_OP_WRITE || op[1] == SDP_OP_WRITE)
                    && e[0] == e[1]);
                fork
                    do_op(0, op[0], a[0], d[0], r[0]);
                    if (both) do_op(1, op[1], a[1], d[1], r[1]);
                join
                for (int p = 0; p < 2; p++) begin
                    if (p == 0 || both) begin
                        cnt[p] = e[p];
                        if (op[p] == SDP_OP_WRITE) begin
                            mem[e[p]] = d[p];
                        end else if (mem.exists(e[p])) begin
                            check(r[p], 32'(mem[e[p]]));
                        end
                    end
                end
            end
        end
        results();
    end
endmodule
`default_nettype wire
